/* hw/crf_framer.sv */
// Purpose: builds and shifts the card response frames onto the command line
// Assumes: start is a one-cycle pulse in the clk domain; inputs stable at start
// Notes:   the link clock is sampled through two flops, one bit per rising edge
//
// Overview of operation
// - responses go out on the command line only, msb first down to bit 0.
// - frame starts with start bit 0 then direction bit 0.
// - crc7 in every response except the ocr response, which sends ones, and the long response, which sends register bits.
// - every frame ends with end bit 1 in position 0.
// - normal response is 48 bits, bits 45:40 hold the command index.
// - normal response carries status in 39:8 and crc7 in 7:1.
// - card may hold data line busy after each written block; host polls.
// - busy response is normal layout, optionally followed by data line busy.
// - cmd2/cmd10/cmd9 answered with 136-bit long response of register contents.
// - long response bits 133:128 all ones, register bits 127:1 follow.
// - ocr response index all ones, ocr in 39:8, ones in 7:1.
// - address response index 000011, address 39:24, status 23,22,19,12:0.
// - interface response index 001000, zeros 39:20, echo voltage and pattern.
// - interface response sent only when the supplied voltage is accepted.
// - voltage codes: 0001 high range, 0010/0100/1000 reserved, others undefined.
// - reserved status bits are always sent as zero.
// - status query argument bit 15 picks card status or task status.
`timescale 1ns/10ps
module crf_framer (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         link_clk,
  input  wire logic         start,
  input  wire logic  [2:0]  kind,
  input  wire logic  [5:0]  cmd_index,
  input  wire logic  [31:0] cmd_arg,
  input  wire logic  [31:0] card_status,
  input  wire logic  [31:0] task_status,
  input  wire logic  [31:0] ocr,
  input  wire logic  [15:0] rca,
  input  wire logic  [127:0] long_reg,
  input  wire logic         busy_req,
  output logic              cmd_out,
  output logic              cmd_oe,
  output logic              dat0_out,
  output logic              dat0_oe,
  output logic              ready,
  output logic              done,
  output logic              volt_rejected
);

  crf_pkg::crf_state_e state;
  crf_pkg::crf_state_e next_state;
  logic [135:0]             shreg;
  logic [135:0]             next_shreg;
  logic [crf_pkg::CNT_W-1:0] cnt;
  logic [crf_pkg::CNT_W-1:0] next_cnt;
  logic                     ocr_frame;
  logic                     next_ocr_frame;
  logic                     long_frame;
  logic                     next_long_frame;
  logic                     next_cmd_out;
  logic                     next_cmd_oe;
  logic                     next_dat0_oe;
  logic                     next_done;
  logic                     next_volt_rejected;
  logic                     lclk_s1;
  logic                     lclk_s2;
  logic                     lclk_prev;
  logic                     tick;
  logic [6:0]               crc;
  logic                     crc_clear;
  logic                     crc_shift;
  logic [31:0]              status_word;
  logic [15:0]              short_status;
  logic [39:0]              body;
  logic                     accept;

  // only the second flop feeds the edge detector
  always_ff @(posedge clk) begin
    if (reset) begin
      lclk_s1   <= 1'b0;
      lclk_s2   <= 1'b0;
      lclk_prev <= 1'b0;
    end else begin
      lclk_s1   <= link_clk;
      lclk_s2   <= lclk_s1;
      lclk_prev <= lclk_s2;
    end
  end

  assign tick = lclk_s2 & ~lclk_prev;

  crf_crc7 u_crc (
    .clk   (clk),
    .reset (reset),
    .clear (crc_clear),
    .shift (crc_shift),
    .din   (shreg[135]),
    .crc   (crc)
  );

  always_comb begin
    status_word = card_status;
    if (cmd_index == crf_pkg::IDX_STATUS && cmd_arg[crf_pkg::SEL_TASK_BIT]) begin
      status_word = task_status;
    end
    status_word = status_word & crf_pkg::STATUS_USED_MASK;
    short_status = {card_status[crf_pkg::ST_CRC_ERR], card_status[crf_pkg::ST_ILLEGAL],
                    card_status[crf_pkg::ST_ERROR], card_status[12:0]};
    // only the high range code is accepted by this card
    accept = (cmd_arg[11:8] == crf_pkg::VOLT_SUPPORTED);
    case (kind)
      crf_pkg::KIND_OCR:    body = {2'b00, crf_pkg::IDX_ONES, ocr};
      crf_pkg::KIND_ADDR:   body = {2'b00, crf_pkg::IDX_ADDR, rca, short_status};
      crf_pkg::KIND_IFCOND: body = {2'b00, crf_pkg::IDX_IFCOND, 20'h00000, cmd_arg[11:8], cmd_arg[7:0]};
      default:              body = {2'b00, cmd_index, status_word};
    endcase
  end

  // crc bit for countdown position; crc is frozen once payload ends
  function automatic logic crc_bit(input logic [crf_pkg::CNT_W-1:0] c);
    logic [2:0] k;
    k = 3'(c - 8'd2);
    crc_bit = crc[k];
  endfunction

  always_comb begin
    next_state         = state;
    next_long_frame    = long_frame;
    next_shreg         = shreg;
    next_cnt           = cnt;
    next_ocr_frame     = ocr_frame;
    next_cmd_out       = cmd_out;
    next_cmd_oe        = cmd_oe;
    next_dat0_oe       = dat0_oe;
    next_done          = 1'b0;
    next_volt_rejected = 1'b0;
    crc_clear          = 1'b0;
    crc_shift          = 1'b0;
    case (state)
      crf_pkg::CRF_IDLE: begin
        next_cmd_oe  = 1'b0;
        next_cmd_out = 1'b1;
        if (start) begin
          crc_clear = 1'b1;
          if (kind == crf_pkg::KIND_IFCOND && !accept) begin
            next_volt_rejected = 1'b1;
          end else if (kind == crf_pkg::KIND_LONG) begin
            next_shreg     = {2'b00, crf_pkg::IDX_ONES, long_reg[127:1], 1'b1};
            next_cnt       = crf_pkg::CNT_W'(crf_pkg::LONG_LEN);
            next_ocr_frame = 1'b0;
            next_long_frame = 1'b1;
            next_state     = crf_pkg::CRF_SEND;
          end else begin
            next_shreg     = {body, 8'h00, 88'h0};
            next_cnt       = crf_pkg::CNT_W'(crf_pkg::SHORT_LEN);
            next_ocr_frame = (kind == crf_pkg::KIND_OCR);
            next_long_frame = 1'b0;
            next_state     = crf_pkg::CRF_SEND;
          end
        end
      end
      crf_pkg::CRF_SEND: begin
        if (tick) begin
          if (cnt == '0) begin
            next_cmd_oe  = 1'b0;
            next_cmd_out = 1'b1;
            if (busy_req) begin
              next_dat0_oe = 1'b1;
              next_state   = crf_pkg::CRF_BUSY;
            end else begin
              next_done  = 1'b1;
              next_state = crf_pkg::CRF_IDLE;
            end
          end else begin
            next_cmd_oe  = 1'b1;
            // the crc takes each payload bit as it is launched, so the full sum is ready for bit 7
            crc_shift    = (cnt > 8'd8);
            next_cmd_out = shreg[135];
            if (!long_frame && cnt <= 8'd8 && cnt >= 8'd2) begin
              // long frames send the register's own crc as plain data
              next_cmd_out = ocr_frame ? crf_pkg::CRC_ONES[0] : crc_bit(cnt);
            end
            if (cnt == 8'd1) begin
              next_cmd_out = 1'b1;
            end
            next_shreg = {shreg[134:0], 1'b0};
            next_cnt   = cnt - 8'd1;
          end
        end
      end
      crf_pkg::CRF_BUSY: begin
        // busy holds while the card is still working
        if (!busy_req) begin
          next_dat0_oe = 1'b0;
          next_done    = 1'b1;
          next_state   = crf_pkg::CRF_IDLE;
        end
      end
      default: begin
        next_state = crf_pkg::CRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state         <= crf_pkg::CRF_IDLE;
      shreg         <= '0;
      cnt           <= '0;
      ocr_frame     <= 1'b0;
      long_frame    <= 1'b0;
      cmd_out       <= 1'b1;
      cmd_oe        <= 1'b0;
      dat0_oe       <= 1'b0;
      done          <= 1'b0;
      volt_rejected <= 1'b0;
    end else begin
      state         <= next_state;
      shreg         <= next_shreg;
      cnt           <= next_cnt;
      ocr_frame     <= next_ocr_frame;
      long_frame    <= next_long_frame;
      cmd_out       <= next_cmd_out;
      cmd_oe        <= next_cmd_oe;
      dat0_oe       <= next_dat0_oe;
      done          <= next_done;
      volt_rejected <= next_volt_rejected;
    end
  end

  assign dat0_out = 1'b0;
  assign ready    = (state == crf_pkg::CRF_IDLE);

endmodule

/* hw/crf_pkg.sv */
// Purpose: shared constants for the card response framer
// Assumes: one response bit per bus clock cycle
// Notes:   bit positions count from the last bit sent (end bit = 0)
package crf_pkg;

  localparam int unsigned SHORT_LEN = 48;
  localparam int unsigned LONG_LEN  = 136;
  localparam int unsigned CNT_W     = 8;

  // response kinds requested by the command decoder
  localparam logic [2:0] KIND_NORMAL = 3'h0;
  localparam logic [2:0] KIND_BUSY   = 3'h1;
  localparam logic [2:0] KIND_LONG   = 3'h2;
  localparam logic [2:0] KIND_OCR    = 3'h3;
  localparam logic [2:0] KIND_ADDR   = 3'h4;
  localparam logic [2:0] KIND_IFCOND = 3'h5;

  localparam logic [5:0] IDX_ADDR    = 6'h03;
  localparam logic [5:0] IDX_IFCOND  = 6'h08;
  localparam logic [5:0] IDX_ONES    = 6'h3f;
  localparam logic [6:0] CRC_ONES    = 7'h7f;
  localparam logic [5:0] IDX_STATUS  = 6'h0d;
  localparam int unsigned SEL_TASK_BIT = 15;

  // voltage codes; only VOLT_SUPPORTED is accepted
  localparam logic [3:0] VOLT_HIGH     = 4'h1;
  localparam logic [3:0] VOLT_LOW_RSV  = 4'h2;
  localparam logic [3:0] VOLT_RSV_A    = 4'h4;
  localparam logic [3:0] VOLT_RSV_B    = 4'h8;
  localparam logic [3:0] VOLT_SUPPORTED = VOLT_HIGH;

  // status word: bits 18 and 17 reserved, 14 and 13 application specific are kept
  localparam logic [31:0] STATUS_USED_MASK = 32'hfff9_ffff;
  localparam int unsigned ST_CRC_ERR  = 23;
  localparam int unsigned ST_ILLEGAL  = 22;
  localparam int unsigned ST_ERROR    = 19;

  localparam logic [6:0] CRC_POLY = 7'h09;

  typedef enum logic [1:0] {
    CRF_IDLE = 2'b00,
    CRF_SEND = 2'b01,
    CRF_BUSY = 2'b11
  } crf_state_e;

endpackage

/* hw/crf_crc7.sv */
// Purpose: serial crc7 accumulator for the command line
// Assumes: clear and shift never asserted together by the caller
// Notes:   x^7 + x^3 + 1, msb first
`timescale 1ns/10ps
module crf_crc7 (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       shift,
  input  wire logic       din,
  output logic      [6:0] crc
);

  logic [6:0] next_crc;
  logic       fb;

  always_comb begin
    fb       = din ^ crc[6];
    next_crc = crc;
    if (clear) begin
      next_crc = 7'h00;
    end else if (shift) begin
      next_crc = {crc[5:0], 1'b0} ^ (fb ? crf_pkg::CRC_POLY : 7'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crc <= 7'h00;
    end else begin
      crc <= next_crc;
    end
  end

endmodule

/* verification/crf_checker.sv */
// Purpose: port checks for crf_framer
// Assumes: link clock far slower than clk
// Notes:   bound into every crf_framer
`timescale 1ns/10ps
module crf_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       start,
  input wire logic [2:0] kind,
  input wire logic       busy_req,
  input wire logic       cmd_out,
  input wire logic       cmd_oe,
  input wire logic       dat0_out,
  input wire logic       dat0_oe,
  input wire logic       ready,
  input wire logic       done,
  input wire logic       volt_rejected
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_bit;
    cmd_oe && $changed(cmd_out);
  endsequence
  sequence s_lead;
    !cmd_out ##1 (!cmd_out) [*8];
  endsequence
  idle_high_a: assert property (!cmd_oe |-> cmd_out) else $error("line not high");
  start_zero_a: assert property ($rose(cmd_oe) |-> s_lead) else $error("bad lead");
  end_one_a: assert property ($fell(cmd_oe) |-> $past(cmd_out)) else $error("bad end");
  bit_hold_a: assert property (s_bit |=> $stable(cmd_out) [*8]) else $error("short bit");
  dat0_low_a: assert property (dat0_oe |-> !dat0_out) else $error("busy not low");
  busy_hold_a: assert property (dat0_oe && busy_req |=> dat0_oe) else $error("busy dropped");
  done_once_a: assert property (done |-> !cmd_oe ##1 !done) else $error("bad done");
  volt_quiet_a: assert property (volt_rejected |-> (!cmd_oe) [*3]) else $error("sent anyway");
  take_req_a: assert property (start && ready && kind != crf_pkg::KIND_IFCOND |=> !ready)
    else $error("not taken");
endmodule
bind crf_framer crf_chk u_chk (.*);

/* verification/crf_host_model.sv */
// Purpose: host side of the command line
// Assumes: line has a pull-up
// Notes:   link clock stands still outside frames
`timescale 1ns/10ps
module crf_host_model (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         run,
  input  wire logic         cmd_out,
  input  wire logic         cmd_oe,
  output logic              link_clk,
  output logic      [135:0] frame,
  output logic      [7:0]   nbits,
  output logic              got
);
  logic line;
  logic oe_q;
  // released line floats to the pull-up
  assign line = cmd_oe ? cmd_out : 1'b1;
  initial begin
    link_clk = 1'b0;
    frame = '0;
    nbits = '0;
  end
  always begin
    #32;
    link_clk = run ? ~link_clk : 1'b0;
  end
  // sample mid-bit, far from the card's update
  always @(negedge link_clk) begin
    if (cmd_oe) begin
      frame <= {frame[134:0], line};
      nbits <= nbits + 8'h1;
    end else begin
      frame <= '0;
      nbits <= '0;
    end
  end
  always @(posedge clk) begin
    oe_q <= reset ? 1'b0 : cmd_oe;
    got <= !reset && oe_q && !cmd_oe;
  end
endmodule

/* verification/tb_top.sv */
// Purpose: frame-level test of crf_framer
// Assumes: host model stops link clock between frames
// Notes:   expected frames built from field layouts
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, reset = 1, start = 0, busy_req = 0, run = 0;
  logic [2:0] kind = 0;
  logic [5:0] cmd_index = 0;
  logic [31:0] cmd_arg = 0, card_status = 0, task_status = 0, ocr = 0, lf = 32'heaeb;
  logic [15:0] rca = 0;
  logic [127:0] long_reg = 0;
  logic link_clk, cmd_out, cmd_oe, dat0_out, dat0_oe, ready, done, volt_rejected, got;
  logic [135:0] frame;
  logic [7:0] nbits;
  logic [135:0] exp_q[$];
  logic [7:0] len_q[$];
  logic [135:0] exp_f;
  logic [7:0] exp_n;
  int n_errors = 0, num_checks = 0;
  always #2 clk = ~clk;
  crf_framer u_crf_framer (.*);
  crf_host_model u_crf_host_model (.*);
  function automatic logic [31:0] rnd();
    repeat (32) lf = {lf[30:0], ^(lf & 32'h80200003)};
    return lf;
  endfunction
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 0;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  function automatic logic [135:0] build(input logic [2:0] k, input logic [5:0] ix,
      input logic [31:0] a, st, ts, oc, input logic [15:0] rc, input logic [127:0] lr);
    logic [31:0] s;
    logic [39:0] h;
    s = (k < 2 && ix == 6'h0d && a[15]) ? ts : st;
    s[18:17] = 2'h0;
    case (k)
      2: return {2'h0, 6'h3f, lr[127:1], 1'b1};
      3: return {2'h0, 6'h3f, oc, 8'hff};
      4: h = {2'h0, 6'h03, rc, s[23], s[22], s[19], s[12:0]};
      5: h = {2'h0, 6'h08, 20'h0, a[11:0]};
      default: h = {2'h0, ix, s};
    endcase
    return {h, crc7(h), 1'b1};
  endfunction
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(input logic w);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge clk);
      if (w ? dat0_oe : (done || volt_rejected)) break;
    end
    if (i == 5000) begin
      chk(0, "timeout");
      end_sim();
    end
  endtask
  task automatic req(input logic [2:0] k, input logic [5:0] ix, input logic [31:0] a, input logic b);
    logic [31:0] s, t, o;
    logic [15:0] r;
    logic [127:0] l;
    logic v;
    s = rnd();
    t = rnd();
    o = rnd();
    r = 16'(rnd());
    l = {rnd(), rnd(), rnd(), rnd()};
    v = k == crf_pkg::KIND_IFCOND && a[11:8] !== 4'h1;
    if (!v) begin
      exp_q.push_back(build(k, ix, a, s, t, o, r, l));
      len_q.push_back(k == crf_pkg::KIND_LONG ? 8'd136 : 8'd48);
    end
    @(posedge clk);
    kind <= k; cmd_index <= ix; cmd_arg <= a; busy_req <= b; start <= 1;
    card_status <= s; task_status <= t; ocr <= o; rca <= r; long_reg <= l;
    @(posedge clk);
    start <= 0;
    run <= 1;
    if (b) begin
      wait_for(1);
      chk(dat0_oe === 1'b1 && cmd_oe === 1'b0, "no busy");
      repeat (5) @(posedge clk);
      busy_req <= 0;
    end
    wait_for(0);
    chk(volt_rejected === v && done === !v, "bad finish");
    run <= 0;
    repeat (30) @(posedge clk);
    $display("test kind %0d index %0d done", k, ix);
  endtask
  always @(posedge clk) if (got) begin
    if (exp_q.size() == 0) chk(0, "extra frame");
    else begin
      // pop both notes first so a bad frame cannot leave the length queue behind
      exp_f = exp_q.pop_front();
      exp_n = len_q.pop_front();
      chk(frame === exp_f && nbits === exp_n, "frame mismatch");
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    for (int k = 0; k < 6; k++) req(3'(k), 6'(rnd()), (rnd() & 32'hfffff0ff) | 32'h100, k == 1);
    req(crf_pkg::KIND_NORMAL, 6'h3f, rnd(), 1);
    req(crf_pkg::KIND_NORMAL, 6'h0d, 32'h8000, 0);
    req(crf_pkg::KIND_BUSY, 6'h0d, 32'h0, 0);
    for (int i = 0; i < 5; i++) begin
      req(crf_pkg::KIND_IFCOND, 6'h08, {20'h0, 4'(i == 4 ? 15 : 1 << i & 14), 8'h5a}, 0);
    end
    req(crf_pkg::KIND_ADDR, 6'h03, 32'h0, 0);
    chk(exp_q.size() == 0, "missing frame");
    end_sim();
  end
endmodule
